// [rtl/rff_pkg.sv]
// Shared constants for the reserved frame filter and ack timing block
package rff_pkg;
    // Symbol timing at the standard data rate
    localparam int SYMBOL_NS     = 16000;
    localparam int CLK_PERIOD_NS = 20;
    localparam logic [9:0] SYM_CYCLES = 10'(SYMBOL_NS / CLK_PERIOD_NS);

    // Ack start delays in symbol periods
    localparam logic [3:0] ACK_STD_SYM   = 4'hC;
    localparam logic [3:0] ACK_SLOT_SYM  = 4'h6;
    localparam logic [3:0] ACK_SHORT_SYM = 4'h2;

    // Frame type codes; codes with bit 2 set are reserved
    localparam logic [2:0] FT_DATA    = 3'h1;
    localparam logic [2:0] FT_COMMAND = 3'h3;
    localparam int         FT_RES_BIT = 2;

    // Transaction status codes
    localparam logic [2:0] TS_SUCCESS  = 3'h0;
    localparam logic [2:0] TS_ACK_WAIT = 3'h1;
    localparam logic [2:0] TS_IDLE     = 3'h7;

    // Ack sequencer, Gray coded along idle, delay, wait trigger
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_DELAY = 2'h1,
        ST_TRIG  = 2'h3
    } rff_state_type;

    typedef struct packed {
        logic          trig_sync1;
        logic          trig_sync2;
        logic          trig_prev;
        rff_state_type state;
        logic [9:0]    div_cnt;
        logic [3:0]    sym_cnt;
        logic [3:0]    target;
        logic          slotted;
        logic          rx_end;
        logic          ami;
        logic          ack_start;
        logic [2:0]    status;
        logic          protect;
        logic          coord;
    } rff_regs_type;
endpackage

// [rtl/rff_core.sv]
// Reserved frame handling, interrupt decision and ack start timing
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Auto-ack mode may accept reserved frame types
// - Upload enable admits reserved frame types
// - Filter enable filters reserved frames like data
// - Unfiltered reserved good frame raises receive end
// - Unfiltered reserved: no address match, ignore ack
// - Filtered reserved frames raise address match
// - Filtered: receive end needs match and good
// - Filtered: ack needs request and receive end
// - Protection bit guards received frame
// - Slotted bit selects slotted ack behaviour
// - Coordinator bit passed to the filter
// - Ack disable bit suppresses automatic ack
// - Version mode limits acknowledged frame versions
// - Standard ack starts twelve symbols after frame
// - Slotted ack triggerable after six symbols, or two with short delay
// - Short ack delay is two symbols
// - Short delay applies under every configuration
// - Slotted ack wait status six symbols after frame, or two with short delay
module rff_core (
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    input  wire logic       auto_ack_receive_mode_in,
    input  wire logic       reserved_frame_upload_en_in,
    input  wire logic       reserved_frame_filter_en_in,
    input  wire logic       frame_protect_en_in,
    input  wire logic       slotted_op_in,
    input  wire logic       pan_coordinator_flag_in,
    input  wire logic       ack_generation_disable_in,
    input  wire logic [1:0] frame_version_ack_mode_in,
    input  wire logic       short_ack_delay_sel_in,
    input  wire logic       frame_done_in,
    input  wire logic [2:0] frame_type_in,
    input  wire logic [1:0] frame_version_in,
    input  wire logic       fcs_ok_in,
    input  wire logic       ack_request_in,
    input  wire logic       addr_match_in,
    input  wire logic       buffer_release_in,
    input  wire logic       sleep_transmit_trigger_in,
    output logic            receive_end_irq_out,
    output logic            address_match_irq_out,
    output logic            ack_tx_start_out,
    output logic [2:0]      transaction_status_field_out,
    output logic            frame_protect_out,
    output logic            pan_coordinator_out
);

    rff_pkg::rff_regs_type st;
    rff_pkg::rff_regs_type next_st;

    logic reserved;
    logic data_like;
    logic rx_end_ev;
    logic ami_ev;
    logic version_ok;
    logic ack_ev;
    logic sym_tick;
    logic trig_edge;

    always_comb begin
        reserved  = frame_type_in[rff_pkg::FT_RES_BIT];
        data_like = (frame_type_in == rff_pkg::FT_DATA) || (frame_type_in == rff_pkg::FT_COMMAND);
        // Version field no higher than the mode code; mode 3 takes all
        version_ok = (frame_version_in <= frame_version_ack_mode_in);
        rx_end_ev = 1'b0;
        ami_ev    = 1'b0;
        if (auto_ack_receive_mode_in && frame_done_in) begin
            if (!reserved) begin
                rx_end_ev = addr_match_in && fcs_ok_in;
                ami_ev    = addr_match_in;
            end else if (reserved_frame_upload_en_in) begin
                if (reserved_frame_filter_en_in) begin
                    rx_end_ev = addr_match_in && fcs_ok_in;
                    ami_ev    = addr_match_in;
                end else begin
                    rx_end_ev = fcs_ok_in;
                    ami_ev    = 1'b0;
                end
            end
        end
        // Unfiltered reserved frames never qualify: request is ignored
        ack_ev = rx_end_ev && ack_request_in && !ack_generation_disable_in && version_ok
                 && (data_like || (reserved && reserved_frame_filter_en_in));
        sym_tick  = (st.div_cnt == rff_pkg::SYM_CYCLES - 10'h001);
        // Edge taken after the second stage only
        trig_edge = st.trig_sync2 && !st.trig_prev;
    end

    always_comb begin
        next_st            = st;
        next_st.trig_sync1 = sleep_transmit_trigger_in;
        next_st.trig_sync2 = st.trig_sync1;
        next_st.trig_prev  = st.trig_sync2;
        next_st.rx_end     = rx_end_ev;
        next_st.ami        = ami_ev;
        next_st.ack_start  = 1'b0;
        next_st.coord      = pan_coordinator_flag_in;
        // New reception sets protection even during a release
        if (!frame_protect_en_in) begin
            next_st.protect = 1'b0;
        end else if (rx_end_ev) begin
            next_st.protect = 1'b1;
        end else if (buffer_release_in) begin
            next_st.protect = 1'b0;
        end
        unique case (st.state)
            rff_pkg::ST_IDLE: begin
                if (ack_ev) begin
                    next_st.state   = rff_pkg::ST_DELAY;
                    next_st.div_cnt = 10'h000;
                    next_st.sym_cnt = 4'h0;
                    next_st.slotted = slotted_op_in;
                    next_st.status  = rff_pkg::TS_IDLE;
                    // Short delay overrides slotted and standard timing
                    if (short_ack_delay_sel_in) begin
                        next_st.target = rff_pkg::ACK_SHORT_SYM;
                    end else if (slotted_op_in) begin
                        next_st.target = rff_pkg::ACK_SLOT_SYM;
                    end else begin
                        next_st.target = rff_pkg::ACK_STD_SYM;
                    end
                end
            end
            rff_pkg::ST_DELAY: begin
                // Frames arriving while an ack is pending are not acknowledged
                if (sym_tick) begin
                    next_st.div_cnt = 10'h000;
                    next_st.sym_cnt = st.sym_cnt + 4'h1;
                    if (st.sym_cnt + 4'h1 == st.target) begin
                        if (st.slotted) begin
                            next_st.state  = rff_pkg::ST_TRIG;
                            next_st.status = rff_pkg::TS_ACK_WAIT;
                        end else begin
                            next_st.state     = rff_pkg::ST_IDLE;
                            next_st.ack_start = 1'b1;
                            next_st.status    = rff_pkg::TS_SUCCESS;
                        end
                    end
                end else begin
                    next_st.div_cnt = st.div_cnt + 10'h001;
                end
            end
            rff_pkg::ST_TRIG: begin
                // Controller owns the exact ack start in slotted mode
                if (trig_edge) begin
                    next_st.state     = rff_pkg::ST_IDLE;
                    next_st.ack_start = 1'b1;
                    next_st.status    = rff_pkg::TS_SUCCESS;
                end
            end
            default: begin
                next_st.state = rff_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '{trig_sync1: 1'b0, trig_sync2: 1'b0, trig_prev: 1'b0, state: rff_pkg::ST_IDLE,
                    div_cnt: 10'h000, sym_cnt: 4'h0, target: 4'h0, slotted: 1'b0, rx_end: 1'b0,
                    ami: 1'b0, ack_start: 1'b0, status: rff_pkg::TS_IDLE, protect: 1'b0, coord: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign receive_end_irq_out          = st.rx_end;
    assign address_match_irq_out        = st.ami;
    assign ack_tx_start_out             = st.ack_start;
    assign transaction_status_field_out = st.status;
    assign frame_protect_out            = st.protect;
    assign pan_coordinator_out          = st.coord;

    property p_unfilt_rx_end;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (auto_ack_receive_mode_in && frame_done_in && reserved && reserved_frame_upload_en_in
         && !reserved_frame_filter_en_in) |=> (receive_end_irq_out == $past(fcs_ok_in));
    endproperty
    a_unfilt_rx_end: assert property (p_unfilt_rx_end) else $error("unfiltered rx end wrong");

    property p_unfilt_no_ami;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (frame_done_in && reserved && !reserved_frame_filter_en_in) |=> !address_match_irq_out;
    endproperty
    a_unfilt_no_ami: assert property (p_unfilt_no_ami) else $error("unfiltered reserved got match");

    property p_filt_ami;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (auto_ack_receive_mode_in && frame_done_in && reserved && reserved_frame_upload_en_in
         && reserved_frame_filter_en_in && addr_match_in) |=> address_match_irq_out;
    endproperty
    a_filt_ami: assert property (p_filt_ami) else $error("filtered reserved match missing");

    property p_filt_rx_end;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (frame_done_in && reserved && reserved_frame_filter_en_in && !(addr_match_in && fcs_ok_in))
        |=> !receive_end_irq_out;
    endproperty
    a_filt_rx_end: assert property (p_filt_rx_end) else $error("filtered rx end without match");

    property p_discard;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (frame_done_in && reserved && !reserved_frame_upload_en_in)
        |=> (!receive_end_irq_out && !address_match_irq_out);
    endproperty
    a_discard: assert property (p_discard) else $error("reserved frame not discarded");

    property p_ack_disable;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.state == rff_pkg::ST_IDLE && ack_generation_disable_in) |=> (st.state == rff_pkg::ST_IDLE);
    endproperty
    a_ack_disable: assert property (p_ack_disable) else $error("ack armed while disabled");

    property p_ack_cause;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ack_tx_start_out |-> ($past(st.state) != rff_pkg::ST_IDLE);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack start without pending ack");

    property p_delay_count;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (ack_tx_start_out && $past(st.state) == rff_pkg::ST_DELAY)
        |-> ($past(st.sym_cnt) + 4'h1 == $past(st.target) && $past(st.div_cnt) == rff_pkg::SYM_CYCLES - 10'h001);
    endproperty
    a_delay_count: assert property (p_delay_count) else $error("ack started before delay");

    property p_slot_wait;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.state == rff_pkg::ST_TRIG && !trig_edge) |=> (!ack_tx_start_out && transaction_status_field_out
        == rff_pkg::TS_ACK_WAIT);
    endproperty
    a_slot_wait: assert property (p_slot_wait) else $error("slotted ack not held for trigger");

    property p_mode_off;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !auto_ack_receive_mode_in |=> (!receive_end_irq_out && !address_match_irq_out);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("event outside auto ack mode");

    property p_data_rx_end;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (auto_ack_receive_mode_in && frame_done_in && !reserved)
        |=> (receive_end_irq_out == $past(addr_match_in && fcs_ok_in));
    endproperty
    a_data_rx_end: assert property (p_data_rx_end) else $error("plain frame rx end wrong");

    property p_data_ami;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (auto_ack_receive_mode_in && frame_done_in && !reserved)
        |=> (address_match_irq_out == $past(addr_match_in));
    endproperty
    a_data_ami: assert property (p_data_ami) else $error("plain frame match wrong");

    property p_filt_rx_end_pos;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (auto_ack_receive_mode_in && frame_done_in && reserved && reserved_frame_upload_en_in
         && reserved_frame_filter_en_in && addr_match_in && fcs_ok_in) |=> receive_end_irq_out;
    endproperty
    a_filt_rx_end_pos: assert property (p_filt_rx_end_pos) else $error("filtered rx end missing");

    property p_unfilt_no_arm;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (frame_done_in && reserved && !reserved_frame_filter_en_in && st.state == rff_pkg::ST_IDLE)
        |=> (st.state == rff_pkg::ST_IDLE);
    endproperty
    a_unfilt_no_arm: assert property (p_unfilt_no_arm) else $error("unfiltered reserved armed ack");

    property p_no_req;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.state == rff_pkg::ST_IDLE && !ack_request_in) |=> (st.state == rff_pkg::ST_IDLE);
    endproperty
    a_no_req: assert property (p_no_req) else $error("ack armed without request");

    property p_filt_arm;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.state == rff_pkg::ST_IDLE && auto_ack_receive_mode_in && frame_done_in && reserved
         && reserved_frame_upload_en_in && reserved_frame_filter_en_in && addr_match_in && fcs_ok_in
         && ack_request_in && !ack_generation_disable_in && frame_version_in <= frame_version_ack_mode_in)
        |=> (st.state == rff_pkg::ST_DELAY);
    endproperty
    a_filt_arm: assert property (p_filt_arm) else $error("filtered reserved ack not armed");

    property p_version;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.state == rff_pkg::ST_IDLE && frame_version_in > frame_version_ack_mode_in)
        |=> (st.state == rff_pkg::ST_IDLE);
    endproperty
    a_version: assert property (p_version) else $error("ack armed for excluded version");

    property p_short_target;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.state == rff_pkg::ST_IDLE && short_ack_delay_sel_in) ##1 (st.state == rff_pkg::ST_DELAY)
        |-> (st.target == rff_pkg::ACK_SHORT_SYM);
    endproperty
    a_short_target: assert property (p_short_target) else $error("short ack delay not chosen");

    property p_std_target;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.state == rff_pkg::ST_IDLE && !short_ack_delay_sel_in && !slotted_op_in)
        ##1 (st.state == rff_pkg::ST_DELAY) |-> (st.target == rff_pkg::ACK_STD_SYM && !st.slotted);
    endproperty
    a_std_target: assert property (p_std_target) else $error("standard ack delay not chosen");

    property p_slot_target;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.state == rff_pkg::ST_IDLE && !short_ack_delay_sel_in && slotted_op_in)
        ##1 (st.state == rff_pkg::ST_DELAY) |-> (st.target == rff_pkg::ACK_SLOT_SYM && st.slotted);
    endproperty
    a_slot_target: assert property (p_slot_target) else $error("slotted ack delay not chosen");

    property p_div_range;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.state == rff_pkg::ST_DELAY) |-> (st.div_cnt < rff_pkg::SYM_CYCLES);
    endproperty
    a_div_range: assert property (p_div_range) else $error("symbol divider overran");

    property p_trig_ack;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.state == rff_pkg::ST_TRIG && trig_edge)
        |=> (ack_tx_start_out && transaction_status_field_out == rff_pkg::TS_SUCCESS);
    endproperty
    a_trig_ack: assert property (p_trig_ack) else $error("trigger did not start ack");

    property p_ack_pulse;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ack_tx_start_out |=> !ack_tx_start_out;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack start longer than one cycle");

    property p_protect_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (receive_end_irq_out && $past(frame_protect_en_in)) |-> frame_protect_out;
    endproperty
    a_protect_set: assert property (p_protect_set) else $error("protection not set on rx end");

    property p_protect_off;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !frame_protect_en_in |=> !frame_protect_out;
    endproperty
    a_protect_off: assert property (p_protect_off) else $error("protection set while disabled");

    property p_coord;
        @(posedge mclk_in) disable iff (!rst_n_in)
        1'b1 |=> (pan_coordinator_out == $past(pan_coordinator_flag_in));
    endproperty
    a_coord: assert property (p_coord) else $error("coordinator flag not passed");

endmodule

`default_nettype wire

// [bench/rff_node.sv]
// Remote radio node model presenting the result of each received frame
`timescale 1ns/1ns
`default_nettype none
module rff_node (
    input  wire logic       mclk_in,
    input  wire logic       send_in,
    input  wire logic [7:0] fields_in,
    output logic            frame_done_out,
    output logic [7:0]      fields_out
);
    logic [7:0] junk = 8'hA5;
    // Fields mean nothing between frames, so they keep changing
    always @(posedge mclk_in) junk <= ~junk;
    assign frame_done_out = send_in;
    assign fields_out     = send_in ? fields_in : junk;
endmodule
`default_nettype wire

// [bench/reserved_frame_filter_ack_timing_bench.sv]
// Self-checking bench for the reserved frame filter and ack timing block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end
module reserved_frame_filter_ack_timing_bench;
    localparam int SYM = int'(rff_pkg::SYM_CYCLES);
    logic       mclk_in  = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       mode = 1'b0, upld = 1'b0, fltr = 1'b0, prot = 1'b0, slot = 1'b0;
    logic       coord = 1'b0, dis = 1'b0, shrt = 1'b0, rel = 1'b0, trig = 1'b0, send = 1'b0;
    logic [1:0] fvm = 2'h0;
    logic [7:0] fin = 8'h00;
    wire        fd;
    wire  [7:0] fo;
    logic       rx_irq, ami_irq, ack_go, protect, coord_o;
    logic [2:0] status;
    int         cyc, n_fail = 0, cmp_count = 0;

    rff_node node_u (.mclk_in(mclk_in), .send_in(send), .fields_in(fin), .frame_done_out(fd), .fields_out(fo));
    rff_core dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .auto_ack_receive_mode_in(mode),
        .reserved_frame_upload_en_in(upld), .reserved_frame_filter_en_in(fltr), .frame_protect_en_in(prot),
        .slotted_op_in(slot), .pan_coordinator_flag_in(coord), .ack_generation_disable_in(dis),
        .frame_version_ack_mode_in(fvm), .short_ack_delay_sel_in(shrt), .frame_done_in(fd),
        .frame_type_in(fo[7:5]), .frame_version_in(fo[4:3]), .fcs_ok_in(fo[2]), .ack_request_in(fo[1]),
        .addr_match_in(fo[0]), .buffer_release_in(rel), .sleep_transmit_trigger_in(trig),
        .receive_end_irq_out(rx_irq), .address_match_irq_out(ami_irq), .ack_tx_start_out(ack_go),
        .transaction_status_field_out(status), .frame_protect_out(protect), .pan_coordinator_out(coord_o));

    initial forever #10 mclk_in = ~mclk_in;

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Fields: type, version, fcs ok, ack request, address match; eack 0 means no ack
    task automatic frame(input logic [7:0] f, input logic erx, eami, input int eack);
        @(posedge mclk_in);
        send <= 1'b1;
        fin  <= f;
        @(posedge mclk_in);
        send <= 1'b0;
        @(negedge mclk_in);
        `CHK("receive_end", erx, rx_irq)
        `CHK("address_match", eami, ami_irq)
        cyc = 0;
        while (ack_go !== 1'b1 && cyc < (eack > 0 ? eack + 50 : 1700)) begin
            @(negedge mclk_in);
            cyc++;
        end
        `CHK("ack_cycle", eack, (ack_go === 1'b1) ? cyc : 0)
        if (eack > 0) `CHK("status_done", rff_pkg::TS_SUCCESS, status)
        @(posedge mclk_in);
    endtask

    initial begin
        #1800000;
        n_fail++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(negedge mclk_in);
        `CHK("status_reset", rff_pkg::TS_IDLE, status)
        `CHK("protect_reset", 1'b0, protect)
        @(posedge mclk_in);
        mode  <= 1'b1;
        prot  <= 1'b1;
        coord <= 1'b1;
        frame({rff_pkg::FT_DATA, 5'b00111}, 1'b1, 1'b1, 12 * SYM);
        `CHK("protect_set", 1'b1, protect)
        `CHK("coord_set", 1'b1, coord_o)
        @(posedge mclk_in);
        rel   <= 1'b1;
        coord <= 1'b0;
        @(posedge mclk_in);
        rel <= 1'b0;
        @(negedge mclk_in);
        `CHK("protect_clear", 1'b0, protect)
        `CHK("coord_clear", 1'b0, coord_o)
        $display("test standard_ack finished");
        @(posedge mclk_in);
        shrt <= 1'b1;
        frame({3'h5, 5'b00111}, 1'b0, 1'b0, 0);
        upld <= 1'b1;
        frame({3'h6, 5'b00110}, 1'b1, 1'b0, 0);
        frame({3'h4, 5'b00111}, 1'b1, 1'b0, 0);
        frame({3'h7, 5'b00011}, 1'b0, 1'b0, 0);
        $display("test unfiltered_reserved finished");
        fltr <= 1'b1;
        frame({3'h5, 5'b00111}, 1'b1, 1'b1, 2 * SYM);
        frame({3'h5, 5'b00110}, 1'b0, 1'b0, 0);
        frame({3'h5, 5'b00101}, 1'b1, 1'b1, 0);
        dis <= 1'b1;
        frame({rff_pkg::FT_COMMAND, 5'b00111}, 1'b1, 1'b1, 0);
        dis  <= 1'b0;
        mode <= 1'b0;
        frame({rff_pkg::FT_DATA, 5'b00111}, 1'b0, 1'b0, 0);
        mode <= 1'b1;
        $display("test filtered_reserved finished");
        for (int m = 0; m < 4; m++) begin
            for (int v = 0; v < 4; v++) begin
                fvm <= 2'(m);
                frame({rff_pkg::FT_DATA, 2'(v), 3'b111}, 1'b1, 1'b1, (v <= m) ? 2 * SYM : 0);
            end
        end
        $display("test version_modes finished");
        shrt <= 1'b0;
        slot <= 1'b1;
        frame({rff_pkg::FT_DATA, 5'b00111}, 1'b1, 1'b1, 0);
        // Trigger during the delay must be ignored
        @(posedge mclk_in);
        trig <= 1'b1;
        repeat (4) @(posedge mclk_in);
        trig <= 1'b0;
        @(negedge mclk_in);
        cyc = 1706;
        while (status !== rff_pkg::TS_ACK_WAIT && cyc < 6000) begin
            @(negedge mclk_in);
            cyc++;
            `CHK("no_early_ack", 1'b0, ack_go)
        end
        `CHK("wait_cycle", 6 * SYM, cyc)
        @(posedge mclk_in);
        trig <= 1'b1;
        cyc = 0;
        while (ack_go !== 1'b1 && cyc < 10) begin
            @(negedge mclk_in);
            cyc++;
        end
        `CHK("trigger_latency", 4, cyc)
        `CHK("status_slot_done", rff_pkg::TS_SUCCESS, status)
        @(posedge mclk_in);
        trig <= 1'b0;
        $display("test slotted_ack finished");
        wrap_up();
    end
endmodule
`default_nettype wire
